/* hdl/dcg_consts.svh */
// Behaviour
// R1: 1KB page: four activates per window.
// R2: 2KB page: four activates per window.
// R3: Two cycles between column commands.
// R4: Write-autoprecharge waits recovery plus precharge.
// R5: Write-to-read gap after last write data.
// R6: Read-to-precharge gap before bank precharge.
// R7: Clock-enable levels held three cycles.
// R8: Self-refresh exit: non-read waits refresh+10ns.
// R9: Self-refresh exit: read waits 200 cycles.
// R10: Precharge power-down exit: two cycles.
// R11: Fast active power-down exit: two cycles.
// R12: Slow active exit: 7/8 minus additive latency.
// R13: Termination stable three cycles before power-down.
// R14: Termination asynchronous eight cycles after exit.
// R15: Two cycles after mode register set.
// R16: New termination setting applied within 12ns; code applies it on a 100 ns system clock edge after decode.
// R17: Drive adjust output within 12ns; code applies it on a 100 ns system clock edge after decode.
// R18: Clock keeps running after enable drops.
// R19: Strobe single-ended or differential by bit.
// R20: Mode bit 12 selects exit speed.
// R21: Read to precharge: additive latency+BL/2.
// R22: Nanosecond intervals round up to cycles.
// R23: Down-counters hold back constrained commands.
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH

// ----------------------------------------------------------------
// Clocks and configuration
// ----------------------------------------------------------------
`define DCG_CLK_PS     100000
`define DCG_CK_HALF    3'h4
`define DCG_TCK_PS     (2 * 4 * `DCG_CLK_PS)
`define DCG_GRADE_800  1
`define DCG_PAGE_2KB   0
`define DCG_CL         5
`define DCG_AL         0
`define DCG_BL         4

// ----------------------------------------------------------------
// Printed times, picoseconds
// ----------------------------------------------------------------
`define DCG_FAW_1K_667_PS 37500
`define DCG_FAW_1K_800_PS 35000
`define DCG_FAW_2K_667_PS 50000
`define DCG_FAW_2K_800_PS 45000
`define DCG_WR_PS      15000
`define DCG_WTR_PS     7500
`define DCG_RTP_PS     7500
`define DCG_RP_PS      15000
`define DCG_RFC_PS     105000
`define DCG_XSNR_PS    (`DCG_RFC_PS + 10000)
`define DCG_MOD_PS     12000
`define DCG_OIT_PS     12000

// ----------------------------------------------------------------
// Derived link-cycle counts, rounded up
// ----------------------------------------------------------------
`define DCG_PS2CK(ps)  (((ps) + `DCG_TCK_PS - 1) / `DCG_TCK_PS)
`define DCG_FAW_PS     (`DCG_PAGE_2KB ? \
  (`DCG_GRADE_800 ? `DCG_FAW_2K_800_PS : `DCG_FAW_2K_667_PS) : \
  (`DCG_GRADE_800 ? `DCG_FAW_1K_800_PS : `DCG_FAW_1K_667_PS))
`define DCG_FAW_CK     `DCG_PS2CK(`DCG_FAW_PS)
`define DCG_WR_CK      `DCG_PS2CK(`DCG_WR_PS)
`define DCG_WTR_CK     `DCG_PS2CK(`DCG_WTR_PS)
`define DCG_RTP_CK     `DCG_PS2CK(`DCG_RTP_PS)
`define DCG_RP_CK      `DCG_PS2CK(`DCG_RP_PS)
`define DCG_XSNR_CK    `DCG_PS2CK(`DCG_XSNR_PS)
`define DCG_CCD_CK     2
`define DCG_CKE_CK     3
`define DCG_XSRD_CK    200
`define DCG_XP_CK      2
`define DCG_XARD_CK    2
`define DCG_XARDS_CK   ((`DCG_GRADE_800 ? 8 : 7) - `DCG_AL)
`define DCG_ANPD_CK    3
`define DCG_AXPD_CK    8
`define DCG_MRD_CK     2
`define DCG_WBURST_CK  (`DCG_CL + `DCG_AL - 1 + `DCG_BL / 2)
`define DCG_RBURST_CK  (`DCG_AL + `DCG_BL / 2)
// Device-side update delays in system clocks, floor, at least one
`define DCG_MOD_CLK    ((`DCG_MOD_PS / `DCG_CLK_PS) < 1 ? 1 : `DCG_MOD_PS / `DCG_CLK_PS)

`endif

/* hdl/dcg_ctrl.sv */
`timescale 1ns/1ps
`include "dcg_consts.svh"
module dcg_ctrl (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  dcg_if.ctrl                    link,
  input  wire logic              req_valid,
  input  wire dcg_pkg::dcg_cmd_t req_cmd,
  input  wire logic [1:0]        req_bank,
  input  wire logic [13:0]       req_addr,
  input  wire logic              req_odt,
  output logic                   req_ack,
  output dcg_pkg::dcg_pwr_t      pwr_state
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] phase;       // Half-period divider
  logic       issue;       // Link clock about to fall
  logic       ok;          // Request legal now
  logic       take;        // Request goes out now
  logic       faw_free;    // A window slot is idle
  logic [1:0] faw_slot;    // Idle slot to load
  logic [7:0] mrd_cnt;     // Mode set spacing
  logic [7:0] ccd_cnt;     // Column spacing
  logic [7:0] wtr_cnt;     // Write to read
  logic [7:0] nonrd_cnt;   // Exit to non-read
  logic [7:0] rd_cnt;      // Exit to read
  logic [7:0] cke_cnt;     // Enable pulse width
  logic [7:0] odt_cnt;     // Termination settle
  logic [7:0] axpd_cnt;    // Termination after exit
  logic [7:0] faw_cnt [4]; // Activate window slots
  logic [7:0] pre_cnt [4]; // Per bank, before precharge
  logic [7:0] dal_cnt [4]; // Per bank, autoprecharge busy
  logic [3:0] open;        // Banks with a row open
  logic       slow_exit;   // Mode bit 12 copy
  logic       up;          // Enable high, no power-down

  // Counter step that stops at zero
  function automatic logic [7:0] dec8(input logic [7:0] c);
    dec8 = (c == 8'h00) ? 8'h00 : c - 8'h01;
  endfunction

  // Larger of two counts
  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  // Free-running even in power-down; never stopped after enable drops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase   <= 3'h0;
      link.ck <= 1'b0;
    end else if (phase == `DCG_CK_HALF - 3'h1) begin
      phase   <= 3'h0;
      link.ck <= ~link.ck; // R18
    end else begin
      phase <= phase + 3'h1;
    end
  end

  // Pins change on the falling edge, stable around the rising one
  assign issue = (phase == `DCG_CK_HALF - 3'h1) && link.ck;
  assign up    = (pwr_state == dcg_pkg::dcg_up) && link.cke;

  // ----------------------------------------------------------------
  // Legality check
  // ----------------------------------------------------------------
  always_comb begin
    faw_free = 1'b0;
    faw_slot = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (faw_cnt[i] == 8'h00) begin
        faw_free = 1'b1;
        faw_slot = 2'(i);
      end
    end
  end

  // Each command waits for every counter that constrains it
  always_comb begin
    ok = 1'b0;
    case (req_cmd)
      dcg_pkg::dcg_act:
        ok = up && mrd_cnt == 8'h00 && nonrd_cnt == 8'h00 && faw_free // R1 R2 R23
             && !open[req_bank] && dal_cnt[req_bank] == 8'h00; // R4
      dcg_pkg::dcg_rd, dcg_pkg::dcg_rda:
        ok = up && mrd_cnt == 8'h00 && rd_cnt == 8'h00 && ccd_cnt == 8'h00 // R3 R9 R11 R12
             && wtr_cnt == 8'h00 && open[req_bank]; // R5
      dcg_pkg::dcg_wr, dcg_pkg::dcg_wra:
        ok = up && mrd_cnt == 8'h00 && nonrd_cnt == 8'h00 && ccd_cnt == 8'h00 // R3
             && open[req_bank];
      dcg_pkg::dcg_pre:
        ok = up && mrd_cnt == 8'h00 && nonrd_cnt == 8'h00 // R8 R10
             && pre_cnt[req_bank] == 8'h00 && dal_cnt[req_bank] == 8'h00; // R6 R21
      dcg_pkg::dcg_mrs, dcg_pkg::dcg_extended_mode_set, dcg_pkg::dcg_ref:
        ok = up && mrd_cnt == 8'h00 && nonrd_cnt == 8'h00 && open == 4'h0; // R15
      dcg_pkg::dcg_sre:
        ok = up && mrd_cnt == 8'h00 && nonrd_cnt == 8'h00 && open == 4'h0
             && cke_cnt == 8'h00 && odt_cnt == 8'h00; // R7 R13
      dcg_pkg::dcg_pde:
        ok = up && mrd_cnt == 8'h00 && cke_cnt == 8'h00 && odt_cnt == 8'h00; // R7 R13
      dcg_pkg::dcg_srx:
        ok = pwr_state == dcg_pkg::dcg_sref && cke_cnt == 8'h00; // R7
      dcg_pkg::dcg_pdx:
        ok = (pwr_state == dcg_pkg::dcg_ppd || pwr_state == dcg_pkg::dcg_apd)
             && cke_cnt == 8'h00; // R7
      default:
        ok = 1'b0;
    endcase
  end

  assign take = issue && req_valid && ok;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // A no-operation goes out on every issue slot without a request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= 4'hf;
      link.cke  <= 1'b0;
      link.ba   <= 2'h0;
      link.addr <= 14'h0;
      req_ack   <= 1'b0;
    end else begin
      req_ack <= take;
      if (issue) begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <=
          take ? dcg_pkg::dcg_encode(req_cmd) : 4'h7;
        link.ba   <= (req_cmd == dcg_pkg::dcg_mrs) ? 2'h0 :
                     (req_cmd == dcg_pkg::dcg_extended_mode_set) ? 2'h1 : req_bank;
        link.addr <= req_addr;
        if (take && (req_cmd == dcg_pkg::dcg_rd || req_cmd == dcg_pkg::dcg_wr
                     || req_cmd == dcg_pkg::dcg_pre))
          link.addr[10] <= 1'b0;
        if (take && (req_cmd == dcg_pkg::dcg_rda || req_cmd == dcg_pkg::dcg_wra))
          link.addr[10] <= 1'b1;
        if (take && (req_cmd == dcg_pkg::dcg_sre || req_cmd == dcg_pkg::dcg_pde))
          link.cke <= 1'b0;
        if (take && (req_cmd == dcg_pkg::dcg_srx || req_cmd == dcg_pkg::dcg_pdx))
          link.cke <= 1'b1;
      end
      // Fourth slot after reset raises enable, once cke_cnt reaches zero
      if (issue && pwr_state == dcg_pkg::dcg_up && !link.cke && cke_cnt == 8'h00)
        link.cke <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power state and bank state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_state <= dcg_pkg::dcg_up;
      open      <= 4'h0;
      slow_exit <= 1'b0;
    end else if (take) begin
      case (req_cmd)
        dcg_pkg::dcg_act: open[req_bank] <= 1'b1;
        dcg_pkg::dcg_pre, dcg_pkg::dcg_rda, dcg_pkg::dcg_wra: open[req_bank] <= 1'b0;
        dcg_pkg::dcg_mrs: slow_exit <= req_addr[12]; // R20
        dcg_pkg::dcg_sre: pwr_state <= dcg_pkg::dcg_sref;
        dcg_pkg::dcg_pde:
          pwr_state <= (open != 4'h0) ? dcg_pkg::dcg_apd : dcg_pkg::dcg_ppd;
        dcg_pkg::dcg_srx, dcg_pkg::dcg_pdx: pwr_state <= dcg_pkg::dcg_up;
        default: pwr_state <= pwr_state;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Global interval counters, one step per link cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mrd_cnt   <= 8'h00;
      ccd_cnt   <= 8'h00;
      wtr_cnt   <= 8'h00;
      nonrd_cnt <= 8'h00;
      rd_cnt    <= 8'h00;
      cke_cnt   <= 8'(`DCG_CKE_CK);
    end else if (issue) begin
      mrd_cnt   <= (take && (req_cmd == dcg_pkg::dcg_mrs || req_cmd == dcg_pkg::dcg_extended_mode_set)) ?
                   8'(`DCG_MRD_CK - 1) : dec8(mrd_cnt); // R15
      ccd_cnt   <= (take && req_cmd inside {dcg_pkg::dcg_rd, dcg_pkg::dcg_rda,
                    dcg_pkg::dcg_wr, dcg_pkg::dcg_wra}) ?
                   8'(`DCG_CCD_CK - 1) : dec8(ccd_cnt); // R3
      // Counted from the last write data, not the command
      wtr_cnt   <= (take && (req_cmd == dcg_pkg::dcg_wr || req_cmd == dcg_pkg::dcg_wra)) ?
                   8'(`DCG_WBURST_CK + `DCG_WTR_CK - 1) : dec8(wtr_cnt); // R5 R22
      nonrd_cnt <= (take && req_cmd == dcg_pkg::dcg_srx) ? 8'(`DCG_XSNR_CK - 1) : // R8
                   (take && req_cmd == dcg_pkg::dcg_pdx) ? 8'(`DCG_XP_CK - 1) :   // R10
                   dec8(nonrd_cnt);
      rd_cnt    <= (take && req_cmd == dcg_pkg::dcg_srx) ? 8'(`DCG_XSRD_CK - 1) : // R9
                   (take && req_cmd == dcg_pkg::dcg_pdx) ?
                   (slow_exit ? 8'(`DCG_XARDS_CK - 1) : 8'(`DCG_XARD_CK - 1)) : // R11 R12
                   dec8(rd_cnt);
      cke_cnt   <= (take && req_cmd inside {dcg_pkg::dcg_sre, dcg_pkg::dcg_pde,
                    dcg_pkg::dcg_srx, dcg_pkg::dcg_pdx}) ?
                   8'(`DCG_CKE_CK - 1) : dec8(cke_cnt); // R7
    end
  end

  // ----------------------------------------------------------------
  // Termination control
  // ----------------------------------------------------------------
  // Frozen in power-down and for eight cycles after exit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link.odt <= 1'b0;
      odt_cnt  <= 8'h00;
      axpd_cnt <= 8'h00;
    end else if (issue) begin
      axpd_cnt <= (take && req_cmd == dcg_pkg::dcg_pdx) ?
                  8'(`DCG_AXPD_CK - 1) : dec8(axpd_cnt); // R14
      if (up && axpd_cnt == 8'h00 && !take && req_odt != link.odt) begin
        link.odt <= req_odt;
        odt_cnt  <= 8'(`DCG_ANPD_CK - 1); // R13
      end else begin
        odt_cnt <= dec8(odt_cnt);
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-bank and window counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        faw_cnt[i] <= 8'h00;
        pre_cnt[i] <= 8'h00;
        dal_cnt[i] <= 8'h00;
      end
    end else if (issue) begin
      for (int i = 0; i < 4; i++) begin
        faw_cnt[i] <= dec8(faw_cnt[i]);
        pre_cnt[i] <= dec8(pre_cnt[i]);
        dal_cnt[i] <= dec8(dal_cnt[i]);
      end
      if (take && req_cmd == dcg_pkg::dcg_act)
        faw_cnt[faw_slot] <= 8'(`DCG_FAW_CK - 1); // R1 R2 R22
      if (take && (req_cmd == dcg_pkg::dcg_rd))
        pre_cnt[req_bank] <= max8(8'(`DCG_RBURST_CK), 8'(`DCG_RTP_CK)) - 8'h01; // R6 R21
      if (take && (req_cmd == dcg_pkg::dcg_wr))
        pre_cnt[req_bank] <= 8'(`DCG_WBURST_CK + `DCG_WR_CK - 1);
      if (take && req_cmd == dcg_pkg::dcg_wra)
        dal_cnt[req_bank] <= 8'(`DCG_WBURST_CK + `DCG_WR_CK + `DCG_RP_CK - 1); // R4
      if (take && req_cmd == dcg_pkg::dcg_rda)
        dal_cnt[req_bank] <= max8(8'(`DCG_RBURST_CK), 8'(`DCG_RTP_CK))
                             + 8'(`DCG_RP_CK - 1);
    end
  end

endmodule

/* hdl/dcg_dev.sv */
`timescale 1ns/1ps
`include "dcg_consts.svh"
module dcg_dev (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  dcg_if.dev                     link,
  output logic                   cmd_seen,
  output dcg_pkg::dcg_cmd_t      cmd_code,
  output logic [1:0]             cmd_bank,
  output logic [13:0]            cmd_addr,
  output dcg_pkg::dcg_pwr_t      pwr_state,
  output logic                   slow_exit,
  output logic                   strobe_diff,
  output logic [1:0]             term_sel,
  output logic [2:0]             drive_sel,
  output logic                   term_sync
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [22:0]       pin_s1;   // First stage, read only by stage two
  logic [22:0]       pin_s2;   // Safe copy of all pins
  logic              ck_d;     // Link clock one cycle ago
  logic              cke_was;  // Enable at previous rising edge
  logic              rise;     // Rising link edge seen
  logic [3:0]        axpd_cnt; // Link edges left of eight after power-down exit
  dcg_pkg::dcg_cmd_t dec;      // Command at this edge

  // All pins through the same two stages, so skew stays equal
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= 23'h0;
      pin_s2 <= 23'h0;
      ck_d   <= 1'b0;
    end else begin
      pin_s1 <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                 link.ba, link.addr, link.odt};
      pin_s2 <= pin_s1;
      ck_d   <= pin_s2[22];
    end
  end

  assign rise = pin_s2[22] & ~ck_d;
  assign dec  = dcg_pkg::dcg_decode(cke_was, pin_s2[21], pin_s2[20:17],
                                    pin_s2[16:15], pin_s2[11]);

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  // One-cycle report per link edge that carries a command
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_seen <= 1'b0;
      cmd_code <= dcg_pkg::dcg_nop;
      cmd_bank <= 2'h0;
      cmd_addr <= 14'h0;
      cke_was  <= 1'b0;
    end else begin
      cmd_seen <= 1'b0;
      if (rise) begin
        cke_was <= pin_s2[21];
        if (dec != dcg_pkg::dcg_nop && !(dec == dcg_pkg::dcg_pdx && pwr_state[0])) begin
          cmd_seen <= 1'b1;
          cmd_code <= (dec == dcg_pkg::dcg_pdx && pwr_state == dcg_pkg::dcg_sref) ?
                      dcg_pkg::dcg_srx : dec;
          cmd_bank <= pin_s2[16:15];
          cmd_addr <= pin_s2[14:1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_state <= dcg_pkg::dcg_up;
    end else if (rise) begin
      case (dec)
        dcg_pkg::dcg_sre: pwr_state <= dcg_pkg::dcg_sref;
        // Active or precharge is the controller's view; here one state
        dcg_pkg::dcg_pde: pwr_state <= dcg_pkg::dcg_ppd;
        dcg_pkg::dcg_pdx: pwr_state <= dcg_pkg::dcg_up;
        default:          pwr_state <= pwr_state;
      endcase
    end
  end

  // Termination timing counts as asynchronous until eight edges pass
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      axpd_cnt  <= 4'h0;
      term_sync <= 1'b1;
    end else begin
      if (rise && dec == dcg_pkg::dcg_pdx)
        axpd_cnt <= 4'(`DCG_AXPD_CK); // R14
      else if (rise && axpd_cnt != 4'h0)
        axpd_cnt <= axpd_cnt - 4'h1;
      term_sync <= (axpd_cnt == 4'h0) && (pwr_state == dcg_pkg::dcg_up); // R14
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  // Applied the cycle after capture, one 100 ns clock, past the 12 ns limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_exit   <= 1'b0;
      strobe_diff <= 1'b1;
      term_sel    <= 2'h0;
      drive_sel   <= 3'h0;
    end else if (rise) begin
      if (dec == dcg_pkg::dcg_mrs)
        slow_exit <= pin_s2[13];           // R20
      if (dec == dcg_pkg::dcg_extended_mode_set) begin
        strobe_diff <= ~pin_s2[11];        // R19
        term_sel    <= {pin_s2[7], pin_s2[3]}; // R16
        drive_sel   <= pin_s2[10:8];       // R17
      end
    end
  end

endmodule

/* hdl/dcg_if.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Command link between controller and memory device
// ----------------------------------------------------------------
interface dcg_if;
  logic        ck;    // Command clock, made by the controller
  logic        cke;   // Clock enable
  logic        cs_n;  // Chip select
  logic        ras_n; // Row strobe
  logic        cas_n; // Column strobe
  logic        we_n;  // Write enable
  logic [1:0]  ba;    // Bank address
  logic [13:0] addr;  // Row, column or mode bits
  logic        odt;   // Termination control

  modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
  modport dev  (input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

/* hdl/dcg_pkg.sv */
package dcg_pkg;

  // ----------------------------------------------------------------
  // Commands as seen by the user of either end
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    dcg_nop  = 4'h0, dcg_act  = 4'h1, dcg_rd   = 4'h2, dcg_rda  = 4'h3,
    dcg_wr   = 4'h4, dcg_wra  = 4'h5, dcg_pre  = 4'h6, dcg_mrs  = 4'h7,
    dcg_extended_mode_set = 4'h8, dcg_ref  = 4'h9, dcg_sre  = 4'ha, dcg_srx  = 4'hb,
    dcg_pde  = 4'hc, dcg_pdx  = 4'hd
  } dcg_cmd_t;

  // Power state, one-hot
  typedef enum logic [3:0] {
    dcg_up   = 4'h1,
    dcg_ppd  = 4'h2,
    dcg_apd  = 4'h4,
    dcg_sref = 4'h8
  } dcg_pwr_t;

  // Command to {cs_n, ras_n, cas_n, we_n}
  function automatic logic [3:0] dcg_encode(input dcg_cmd_t c);
    case (c)
      dcg_act:          dcg_encode = 4'h3;
      dcg_rd, dcg_rda:  dcg_encode = 4'h5;
      dcg_wr, dcg_wra:  dcg_encode = 4'h4;
      dcg_pre:          dcg_encode = 4'h2;
      dcg_ref, dcg_sre: dcg_encode = 4'h1;
      dcg_mrs, dcg_extended_mode_set: dcg_encode = 4'h0;
      default:          dcg_encode = 4'h7;
    endcase
  endfunction

  // Pins at a rising link edge back to a command; exit is dcg_pdx
  function automatic dcg_cmd_t dcg_decode(input logic cke_was, input logic cke,
                                          input logic [3:0] pins, input logic [1:0] ba,
                                          input logic a10);
    if (!cke_was && cke)
      dcg_decode = dcg_pdx;
    else if (!cke)
      dcg_decode = (cke_was && pins == 4'h1) ? dcg_sre :
                   (cke_was ? dcg_pde : dcg_nop);
    else begin
      case (pins)
        4'h3:    dcg_decode = dcg_act;
        4'h5:    dcg_decode = a10 ? dcg_rda : dcg_rd;
        4'h4:    dcg_decode = a10 ? dcg_wra : dcg_wr;
        4'h2:    dcg_decode = dcg_pre;
        4'h1:    dcg_decode = dcg_ref;
        4'h0:    dcg_decode = (ba == 2'h1) ? dcg_extended_mode_set : dcg_mrs;
        default: dcg_decode = dcg_nop;
      endcase
    end
  endfunction

endpackage

/* verif/dcg_link_checker.sv */
`timescale 1ns/1ps
// ------
// Link spacing checks
// ------
module dcg_link_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ck,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  ba,
  input wire logic [13:0] addr,
  input wire logic        odt
);
  logic       ck_d, cke_d, odt_d, in_sref; // Delayed copies, refresh flag
  logic [6:0] c_cke, c_odt, c_wr, c_rd; // Saturating clk counters
  wire  [3:0] pins = {cs_n, ras_n, cas_n, we_n};
  wire        rise = ck & ~ck_d; // Link rising edge
  wire        colp = cke & (pins[3:1] == 3'h2);
  wire        idle = pins[3] | (pins[2:0] == 3'h7);
  // Restart at event, stick at top so idle links never wrap
  function automatic logic [6:0] sat(input logic [6:0] c, input logic clr);
    sat = clr ? 7'h00 : c + 7'(c != 7'h7f);
  endfunction
  // Helper state; refresh flag starts set to mask the first rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {ck_d, cke_d, odt_d, in_sref} <= 4'h1;
      {c_cke, c_odt, c_wr, c_rd} <= '1;
    end else begin
      {ck_d, cke_d, odt_d} <= {ck, cke, odt};
      if (cke_d & ~cke) in_sref <= (pins == 4'h1);
      c_cke <= sat(c_cke, cke != cke_d);
      c_odt <= sat(c_odt, odt != odt_d);
      c_wr <= sat(c_wr, rise & colp & ~we_n);
      c_rd <= sat(c_rd, rise & colp & we_n);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_idle; ##8 idle; endsequence
  property p_ccd; rise && colp |-> ##8 !colp; endproperty
  property p_mrd; rise && cke && pins == 4'h0 |-> s_idle; endproperty
  property p_cke; cke != cke_d |-> c_cke >= 7'h17; endproperty
  property p_xp; rise && cke && !$past(cke, 8) && !in_sref |-> s_idle; endproperty
  property p_anpd; cke_d && !cke |-> c_odt >= 7'h17; endproperty
  property p_axpd; odt != odt_d && cke |-> c_cke >= 7'h3f; endproperty
  property p_wtr; rise && colp && we_n |-> c_wr >= 7'h37; endproperty
  property p_rtp; rise && cke && pins == 4'h2 |-> c_rd >= 7'h0f; endproperty
  a_ccd: assert property (p_ccd) else $error("column gap short");
  a_mrd: assert property (p_mrd) else $error("mode set gap short");
  a_cke: assert property (p_cke) else $error("clock enable pulse short");
  a_xp: assert property (p_xp) else $error("power-down exit gap short");
  a_anpd: assert property (p_anpd) else $error("termination moved before entry");
  a_axpd: assert property (p_axpd) else $error("termination moved after exit");
  a_wtr: assert property (p_wtr) else $error("write to read gap short");
  a_rtp: assert property (p_rtp) else $error("read to precharge short");
endmodule

/* verif/ddr2_command_timing_guard_tb.sv */
`timescale 1ns/1ps
module ddr2_command_timing_guard_tb;
  logic              clk = 1'h0, sys_rst = 1'h1, req_valid = 1'h0, req_odt = 1'h0;
  logic              req_ack, cmd_seen, slow_exit, strobe_diff, term_sync;
  logic [1:0]        req_bank = 2'h0, cmd_bank, term_sel;
  logic [2:0]        drive_sel;
  logic [13:0]       req_addr = 14'h0, cmd_addr;
  logic [19:0]       e, exp_q[$]; // Expected decoded words
  dcg_pkg::dcg_cmd_t req_cmd = dcg_pkg::dcg_nop, cmd_code;
  dcg_pkg::dcg_pwr_t pwr_c, pwr_d;
  int                num_errors = 0, n_checks = 0, cyc = 0, last = 0;
  dcg_if link();
  dcg_ctrl dcg_ctrl_i (.clk, .sys_rst, .link(link.ctrl), .req_valid, .req_cmd, .req_bank,
    .req_addr, .req_odt, .req_ack, .pwr_state(pwr_c));
  dcg_dev dcg_dev_i (.clk, .sys_rst, .link(link.dev), .cmd_seen, .cmd_code, .cmd_bank,
    .cmd_addr, .pwr_state(pwr_d), .slow_exit, .strobe_diff, .term_sel, .drive_sel, .term_sync);
  dcg_link_checker dcg_link_checker_i (.clk, .sys_rst, .ck(link.ck), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .ba(link.ba), .addr(link.addr), .odt(link.odt));
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Device view; power commands compared by code only
  always @(posedge clk) if (cmd_seen === 1'h1) begin
    e = exp_q.size() ? exp_q.pop_front() : '1;
    chk({cmd_code, cmd_bank, cmd_addr} & (e[19:16] < 4'h9 ? '1 : 20'hf0000),
        e & (e[19:16] < 4'h9 ? '1 : 20'hf0000));
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One request; gp is the expected slot gap from the last ack
  task automatic issue(input dcg_pkg::dcg_cmd_t c, input logic [1:0] b,
                       input logic [13:0] a, input int gp);
    int n;
    @(posedge clk);
    {req_valid, req_cmd, req_bank, req_addr} <= {1'h1, c, b, a};
    for (n = 0; n < 2000 && req_ack !== 1'h1; n++) @(posedge clk);
    if (n == 2000) begin num_errors++; end_of_test; end
    req_valid <= 1'h0;
    if (gp > 0) chk(20'(cyc - last), 20'(gp * 8));
    last = cyc;
    exp_q.push_back({c, b, a});
  endtask
  // Wait until the device has reported everything sent
  task automatic settle;
    int n;
    for (n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge clk);
    if (n == 40) begin num_errors++; end_of_test; end
    @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    issue(dcg_pkg::dcg_mrs, 2'h0, 14'h0, 0);
    issue(dcg_pkg::dcg_extended_mode_set, 2'h1, 14'h06c0, 2);
    settle;
    chk(20'({strobe_diff, term_sel, drive_sel}), 20'({1'h0, 2'h2, 3'h5}));
    issue(dcg_pkg::dcg_act, 2'h0, 14'h0012, 0);
    issue(dcg_pkg::dcg_wr, 2'h0, 14'h0008, 0);
    issue(dcg_pkg::dcg_rd, 2'h0, 14'h0008, 7);
    issue(dcg_pkg::dcg_rd, 2'h0, 14'h0000, 2);
    issue(dcg_pkg::dcg_pre, 2'h0, 14'h0000, 2);
    req_odt <= 1'h1;
    issue(dcg_pkg::dcg_pde, 2'h0, 14'h0, 0);
    settle;
    chk(20'({pwr_c, pwr_d, term_sync}), 20'({dcg_pkg::dcg_ppd, dcg_pkg::dcg_ppd, 1'h0}));
    issue(dcg_pkg::dcg_pdx, 2'h0, 14'h0, 3);
    // Fast then slow active power-down exit
    for (int m = 0; m < 2; m++) begin
      issue(dcg_pkg::dcg_mrs, 2'h0, m ? 14'h1000 : 14'h0, m ? 0 : 2);
      issue(dcg_pkg::dcg_act, 2'h1, 14'h0005, 0);
      req_odt <= m[0];
      repeat (8) @(posedge clk);
      issue(dcg_pkg::dcg_pde, 2'h0, 14'h0, 0);
      settle;
      chk(20'({pwr_c, pwr_d, slow_exit}), 20'({dcg_pkg::dcg_apd, dcg_pkg::dcg_ppd, m[0]}));
      issue(dcg_pkg::dcg_pdx, 2'h0, 14'h0, 3);
      issue(dcg_pkg::dcg_rd, 2'h1, 14'h0004, m ? 8 : 2);
      issue(dcg_pkg::dcg_pre, 2'h1, 14'h0000, 2);
    end
    issue(dcg_pkg::dcg_sre, 2'h0, 14'h0, 0);
    settle;
    chk(20'({pwr_c, pwr_d}), 20'({dcg_pkg::dcg_sref, dcg_pkg::dcg_sref}));
    issue(dcg_pkg::dcg_srx, 2'h0, 14'h0, 3);
    issue(dcg_pkg::dcg_act, 2'h2, 14'h0007, 1);
    issue(dcg_pkg::dcg_rd, 2'h2, 14'h0000, 199);
    settle;
    end_of_test;
  end
endmodule
